// file: module_defaults.sv
// Default power slot enables derived from the captured boot source.
`timescale 1ns/1ps
module module_defaults #(
   parameter int NUM_SLOTS = 22
) (
   input wire logic [2:0] boot_source_sel,
   output logic [NUM_SLOTS-1:0] slot_enable
);
   strap_pkg::boot_src_t src;
   always_comb begin
      src = strap_pkg::boot_src_t'(boot_source_sel);
      slot_enable = '0;
      case (src)
         strap_pkg::boot_rom_nand,
         strap_pkg::boot_ext_bus: begin
            slot_enable[0] = 1'b1; // R10
            slot_enable[1] = 1'b1; // R10
            slot_enable[14] = 1'b1; // R10
         end
         strap_pkg::boot_rom_card: begin
            slot_enable[15] = 1'b1; // R12
         end
         strap_pkg::boot_rom_uart: begin
            slot_enable[19] = 1'b1; // R11
         end
         strap_pkg::boot_rom_usb: begin
            slot_enable[0] = 1'b1; // R10
            slot_enable[1] = 1'b1; // R10
            slot_enable[9] = 1'b1; // R12
         end
         strap_pkg::boot_rom_eth: begin
            slot_enable[0] = 1'b1; // R10
            slot_enable[1] = 1'b1; // R10
         end
         strap_pkg::boot_rom_host: begin
            slot_enable[21] = 1'b1; // R12
         end
         default: begin
            slot_enable = '0;
         end
      endcase
   end
endmodule

// file: strap_board.sv
// Board model: strap levels until the pins are handed over, bus traffic afterwards.
`timescale 1ns/1ps
module strap_board (
   input logic aclk,
   input logic drive_en,
   input logic [6:0] strap_val,
   input logic strap_pins_as_bus,
   output logic [13:8] ext_bus_addr_pins,
   output logic general_io_pin_81
);
   logic [6:0] act_q = 7'h00;
   always_ff @(posedge aclk) begin
      act_q <= act_q + 7'h13;
   end
   // Traffic changes every cycle, so a stale capture cannot hide.
   assign {general_io_pin_81, ext_bus_addr_pins} = strap_pins_as_bus ?
      act_q : drive_en ? strap_val : 7'h00;
endmodule

// file: strap_latch.sv
// Reset strap latch with module defaults and an AXI4-Lite control and status port.
// How it works
// R01: Capture boot, bus and oscillator straps at reset.
// R02: Return strap pins to memory bus afterwards.
// R03: Boot source from address lines 13 to 11.
// R04: Eight boot-source codes select boot mode.
// R05: Undriven boot straps read as 000.
// R06: Bus config from lines 10 to 8.
// R07: Oscillator mode sampled from pin 81.
// R08: Clock generators disabled and bypassed after reset.
// R09: Boot source picks default module enables.
// R10: Slots 0, 1, 14 by boot source.
// R11: Boot source 011 enables first UART.
// R12: Slots 15, 9, 21 conditional; others off.
// R13: Start at ROM 0x8000 unless 001.
// R14: Bus config only sets default pin mux. The code also drives bus_16bit from its bit 2.
// R15: Captured values hold until next reset.
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "strap_regs.svh"
module strap_latch #(
   parameter int NUM_SLOTS = 22,
   parameter int SETTLE_CYCLES = `SETTLE_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [13:8] ext_bus_addr_pins,
   input wire logic general_io_pin_81,
   output logic strap_pins_as_bus,
   output logic strap_valid,
   output logic [2:0] boot_source_sel,
   output logic [2:0] ext_bus_cfg,
   output logic osc_mode_sel,
   output logic bus_16bit,
   output logic [31:0] boot_addr,
   output logic pll_bypass,
   output logic pll_enable,
   output logic [NUM_SLOTS-1:0] local_power_slot,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // Pins are asynchronous: three stages, a change counts when 2 and 3 agree.
   logic [6:0] sync1_q, sync2_q, sync3_q, stable_q, stable_d;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= `STRAP_DEFAULT;
         sync2_q <= `STRAP_DEFAULT;
         sync3_q <= `STRAP_DEFAULT;
         stable_q <= `STRAP_DEFAULT;
      end else begin
         sync1_q <= {general_io_pin_81, ext_bus_addr_pins}; // R03 R06 R07
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         stable_q <= stable_d;
      end
   end
   always_comb begin
      stable_d = stable_q;
      for (int i = 0; i < 7; i++) begin
         if (sync2_q[i] == sync3_q[i]) begin
            stable_d[i] = sync3_q[i];
         end
      end
   end

   // Capture sequencer. Reset clears the capture so undriven straps, which
   // the pad pulls hold low, give the 000 defaults.
   strap_pkg::cap_state_t state_q, state_d;
   logic [15:0] cnt_q, cnt_d;
   logic [6:0] cap_q, cap_d;
   logic valid_q, valid_d;
   logic bypass_q, bypass_d;
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      cap_d = cap_q;
      valid_d = valid_q;
      case (state_q)
         strap_pkg::st_settle: begin
            if (cnt_q >= 16'(SETTLE_CYCLES)) begin
               state_d = strap_pkg::st_capture;
            end else begin
               cnt_d = cnt_q + 16'h0001;
            end
         end
         strap_pkg::st_capture: begin
            cap_d = stable_q; // R01 R05
            valid_d = 1'b1;
            state_d = strap_pkg::st_run; // R02
         end
         strap_pkg::st_run: begin
            // Captured values are frozen; pin activity is ignored here.
            cap_d = cap_q; // R15
         end
         default: begin
            state_d = strap_pkg::st_settle;
         end
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= strap_pkg::st_settle;
         cnt_q <= 16'h0000;
         cap_q <= `STRAP_DEFAULT;
         valid_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         cap_q <= cap_d;
         valid_q <= valid_d;
      end
   end

   // Clock generator bypass: set by every reset, software may clear it.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bypass_q <= 1'b1; // R08
      end else begin
         bypass_q <= bypass_d;
      end
   end

   // Outputs.
   assign boot_source_sel = cap_q[5:3]; // R03 R04
   module_defaults #(
      .NUM_SLOTS(NUM_SLOTS)
   ) u_defaults (
      .boot_source_sel(cap_q[5:3]),
      .slot_enable(local_power_slot) // R09 R10 R11 R12
   );
   always_comb begin
      strap_pins_as_bus = valid_q; // R02
      strap_valid = valid_q;
      ext_bus_cfg = cap_q[2:0]; // R06 R14
      osc_mode_sel = cap_q[6]; // R07
      bus_16bit = cap_q[2]; // R06
      pll_bypass = bypass_q; // R08
      pll_enable = ~bypass_q; // R08
      if (cap_q[5:3] == 3'(strap_pkg::boot_ext_bus)) begin
         boot_addr = `BOOT_FLASH_ADDR; // R13
      end else begin
         boot_addr = `BOOT_ROM_ADDR; // R13
      end
   end
   // AXI4-Lite slave. One write and one read at a time; reads answer in one cycle, writes in two.
   logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
   logic [11:0] awa_q, awa_d;
   logic [31:0] wd_q, wd_d, rd_q, rd_d;
   logic [1:0] br_q, br_d, rr_q, rr_d;

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == `OFF_CTRL) || (a == `OFF_STRAP) ||
         (a == `OFF_MODEN) || (a == `OFF_BOOT);
   endfunction

   assign s_axi_awready = ~aw_q & ~bv_q;
   assign s_axi_wready = ~w_q & ~bv_q;
   assign s_axi_arready = ~rv_q;
   assign s_axi_bvalid = bv_q;
   assign s_axi_bresp = br_q;
   assign s_axi_rvalid = rv_q;
   assign s_axi_rdata = rd_q;
   assign s_axi_rresp = rr_q;

   always_comb begin
      aw_d = aw_q;
      w_d = w_q;
      awa_d = awa_q;
      wd_d = wd_q;
      bv_d = bv_q;
      br_d = br_q;
      rv_d = rv_q;
      rd_d = rd_q;
      rr_d = rr_q;
      bypass_d = bypass_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_d = 1'b1;
         awa_d = {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_d = 1'b1;
         wd_d = s_axi_wdata;
      end
      if (aw_q && w_q) begin
         aw_d = 1'b0;
         w_d = 1'b0;
         bv_d = 1'b1;
         br_d = mapped(awa_q) ? 2'b00 : 2'b10;
         if (awa_q == `OFF_CTRL && s_axi_wstrb[0]) begin
            bypass_d = wd_q[`BIT_CTRL_BYPASS];
         end
      end
      if (bv_q && s_axi_bready) begin
         bv_d = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rv_d = 1'b1;
         rr_d = 2'b00;
         rd_d = 32'h0000_0000;
         case ({s_axi_araddr[11:2], 2'b00})
            `OFF_CTRL: begin
               rd_d[`BIT_CTRL_PIN_OWN] = valid_q;
               rd_d[`BIT_CTRL_BYPASS] = bypass_q;
            end
            `OFF_STRAP: begin
               rd_d[`FLD_BOOT_LO +: 3] = cap_q[5:3];
               rd_d[`FLD_BUS_LO +: 3] = cap_q[2:0];
               rd_d[`FLD_OSC] = cap_q[6];
               rd_d[`FLD_VALID] = valid_q;
            end
            `OFF_MODEN: begin
               rd_d[NUM_SLOTS-1:0] = local_power_slot;
            end
            `OFF_BOOT: begin
               rd_d = boot_addr;
            end
            default: begin
               rr_d = 2'b10;
            end
         endcase
      end else if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awa_q <= 12'h000;
         wd_q <= 32'h0000_0000;
         bv_q <= 1'b0;
         br_q <= 2'b00;
         rv_q <= 1'b0;
         rd_q <= 32'h0000_0000;
         rr_q <= 2'b00;
      end else begin
         aw_q <= aw_d;
         w_q <= w_d;
         awa_q <= awa_d;
         wd_q <= wd_d;
         bv_q <= bv_d;
         br_q <= br_d;
         rv_q <= rv_d;
         rd_q <= rd_d;
         rr_q <= rr_d;
      end
   end
endmodule

// file: strap_monitor.sv
// Concurrent checks on the strap latch outputs.
`timescale 1ns/1ps
module strap_monitor #(
   parameter int NUM_SLOTS = 22
) (
   input logic aclk,
   input logic aresetn,
   input logic [13:8] ext_bus_addr_pins,
   input logic general_io_pin_81,
   input logic strap_pins_as_bus,
   input logic strap_valid,
   input logic [2:0] boot_source_sel,
   input logic [2:0] ext_bus_cfg,
   input logic osc_mode_sel,
   input logic bus_16bit,
   input logic [31:0] boot_addr,
   input logic pll_bypass,
   input logic pll_enable,
   input logic [NUM_SLOTS-1:0] local_power_slot,
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic s_axi_rvalid,
   input logic s_axi_rready
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   logic [2:0] b;
   logic [21:0] s;
   assign b = boot_source_sel;
   assign s = local_power_slot;
   a_pll_pair: assert property (pll_enable == !pll_bypass)
      else $error("pll enable not inverse of bypass");
   a_bypass_reset: assert property ($rose(aresetn) |-> pll_bypass)
      else $error("clock generators not bypassed after reset");
   a_pin_handover: assert property (strap_pins_as_bus == strap_valid)
      else $error("pin handover differs from capture state");
   a_valid_soon: assert property ($rose(aresetn) |-> ##[1:40] strap_valid)
      else $error("straps not captured after reset");
   // The pins are taken one edge back, since the board drives bus traffic
   // as soon as the pins are handed over.
   a_capture_pins: assert property ($rose(strap_valid) |-> {osc_mode_sel,
      b, ext_bus_cfg} == $past({general_io_pin_81, ext_bus_addr_pins}))
      else $error("captured values differ from strap pins");
   a_caps_hold: assert property (strap_valid && $past(strap_valid)
      |-> $stable({osc_mode_sel, b, ext_bus_cfg}))
      else $error("captured values changed");
   a_bus_width: assert property (bus_16bit == ext_bus_cfg[2])
      else $error("bus width flag wrong");
   a_boot_addr: assert property (boot_addr == ((b == 3'h1) ?
      32'h0000_0000 : 32'h0000_8000))
      else $error("boot address wrong");
   a_dma_slots: assert property ({s[14], s[1:0]} == {b < 3'h2,
      {2{b inside {3'h0, 3'h1, 3'h4, 3'h6}}}})
      else $error("dma or bus slot enables wrong");
   a_boot_slots: assert property ({s[21], s[19], s[15], s[9]} ==
      {b == 3'h7, b == 3'h3, b == 3'h2, b == 3'h4})
      else $error("boot dependent slot enables wrong");
   a_slots_off: assert property ((s & 22'h17_3DFC) == 22'h0)
      else $error("unlisted slot enabled");
   cover property ($rose(strap_valid) && b == 3'h7);
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (s_axi_rvalid && s_axi_rready);
endmodule

// file: strap_pkg.sv
// Types shared by the strap latch design.
package strap_pkg;
   typedef enum logic [2:0] {
      boot_rom_nand,
      boot_ext_bus,
      boot_rom_card,
      boot_rom_uart,
      boot_rom_usb,
      boot_rom_spi,
      boot_rom_eth,
      boot_rom_host
   } boot_src_t;
   typedef enum logic [1:0] {
      st_settle,
      st_capture,
      st_run
   } cap_state_t;
endpackage

// file: strap_regs.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef STRAP_REGS_SVH
`define STRAP_REGS_SVH
`define OFF_CTRL 12'h000
`define OFF_STRAP 12'h004
`define OFF_MODEN 12'h008
`define OFF_BOOT 12'h00c
`define BIT_CTRL_RESAMPLE 0
`define BIT_CTRL_PIN_OWN 1
`define BIT_CTRL_BYPASS 2
`define FLD_BOOT_LO 0
`define FLD_BUS_LO 4
`define FLD_OSC 8
`define FLD_VALID 9
`define BOOT_ROM_ADDR 32'h0000_8000
`define BOOT_FLASH_ADDR 32'h0000_0000
`define STRAP_DEFAULT 7'h00
`define SETTLE_NS 100
`define SETTLE_CYC ((`SETTLE_NS + 9) / 10)
`endif

// file: tb.sv
// Self-checking bench for the strap latch.
`timescale 1ns/1ps
`include "strap_regs.svh"
`define CHK(n, e, a) \
   begin \
      cmp_count++; \
      if ((a) !== (e)) begin \
         err_count++; \
         $display("wrong value %s expected %h seen %h", n, e, a); \
      end \
   end
module tb;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic drive_en = 1'b1;
   logic [6:0] strap_val = 7'h00;
   logic [13:8] ext_bus_addr_pins;
   logic general_io_pin_81, strap_pins_as_bus, strap_valid, osc_mode_sel;
   logic bus_16bit, pll_bypass, pll_enable;
   logic [2:0] boot_source_sel, ext_bus_cfg;
   logic [31:0] boot_addr, s_axi_rdata;
   logic [21:0] local_power_slot;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   // The default settle count is kept: the capture must wait until the
   // three-stage pin synchroniser has filled after reset.
   strap_latch strap_latch_inst (.aclk, .aresetn,
      .ext_bus_addr_pins, .general_io_pin_81, .strap_pins_as_bus,
      .strap_valid, .boot_source_sel, .ext_bus_cfg, .osc_mode_sel,
      .bus_16bit, .boot_addr, .pll_bypass, .pll_enable, .local_power_slot,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   strap_board strap_board_inst (.aclk, .drive_en, .strap_val,
      .strap_pins_as_bus, .ext_bus_addr_pins, .general_io_pin_81);
   initial begin
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         summarize();
      end
   end
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
         output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d,
         output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   function automatic logic [21:0] exp_slots(input logic [2:0] b);
      logic [21:0] s;
      s = 22'h0;
      s[0] = b inside {3'h0, 3'h1, 3'h4, 3'h6};
      s[1] = s[0];
      s[14] = b < 3'h2;
      s[9] = b == 3'h4;
      s[15] = b == 3'h2;
      s[19] = b == 3'h3;
      s[21] = b == 3'h7;
      return s;
   endfunction
   task automatic reset_to(input logic [6:0] v, input logic en);
      @(posedge aclk);
      aresetn <= 1'b0;
      strap_val <= v;
      drive_en <= en;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      do @(posedge aclk); while (strap_valid !== 1'b1);
   endtask
   task automatic check_caps(input logic [6:0] v);
      logic [31:0] d, e;
      logic [1:0] r;
      logic [2:0] b;
      b = v[5:3];
      e = (b == 3'h1) ? 32'h0000_0000 : 32'h0000_8000;
      `CHK("boot", b, boot_source_sel)
      `CHK("bus cfg", v[2:0], ext_bus_cfg)
      `CHK("osc", v[6], osc_mode_sel)
      `CHK("width", v[2], bus_16bit)
      `CHK("pins", 1'b1, strap_pins_as_bus)
      `CHK("boot addr", e, boot_addr)
      `CHK("slots", exp_slots(b), local_power_slot)
      rd(`OFF_STRAP, d, r);
      `CHK("strap reg", {22'h0, 1'b1, v[6], 1'b0, v[2:0], 1'b0, b}, d)
      rd(`OFF_MODEN, d, r);
      `CHK("slot reg", {10'h0, exp_slots(b)}, d)
      rd(`OFF_BOOT, d, r);
      `CHK("boot reg", e, d)
   endtask
   task automatic t_boot_codes();
      logic [2:0] b;
      for (int i = 0; i < 8; i++) begin
         b = i[2:0];
         reset_to({b[0], b, ~b}, 1'b1);
         check_caps({b[0], b, ~b});
      end
      $display("test boot codes done");
   endtask
   task automatic t_undriven();
      reset_to(7'h7F, 1'b0);
      check_caps(7'h00);
      $display("test undriven straps done");
   endtask
   task automatic t_hold();
      reset_to(7'h2B, 1'b1);
      repeat (20) @(posedge aclk);
      check_caps(7'h2B);
      $display("test capture hold done");
   endtask
   task automatic t_ctrl();
      logic [31:0] d;
      logic [1:0] r;
      rd(`OFF_CTRL, d, r);
      `CHK("ctrl", 2'b11, d[2:1])
      wr(`OFF_CTRL, 32'h0000_0000, r);
      `CHK("ctrl resp", 2'b00, r)
      rd(`OFF_CTRL, d, r);
      `CHK("bypass off", 1'b0, d[2])
      `CHK("pll on", 1'b1, pll_enable)
      wr(12'h010, 32'h0000_0004, r);
      `CHK("bad write", 2'b10, r)
      `CHK("pll still on", 1'b1, pll_enable)
      rd(12'h010, d, r);
      `CHK("bad read", 2'b10, r)
      `CHK("bad data", 32'h0000_0000, d)
      reset_to(7'h00, 1'b1);
      `CHK("bypass again", 1'b1, pll_bypass)
      s_axi_wstrb <= 4'h0;
      wr(`OFF_CTRL, 32'h0000_0000, r);
      s_axi_wstrb <= 4'hF;
      `CHK("masked resp", 2'b00, r)
      `CHK("masked write", 1'b1, pll_bypass)
      `CHK("masked pll", 1'b0, pll_enable)
      $display("test control done");
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      t_boot_codes();
      t_undriven();
      t_hold();
      t_ctrl();
      summarize();
   end
endmodule
bind strap_latch strap_monitor #(.NUM_SLOTS(NUM_SLOTS)) strap_monitor_inst (
   .aclk, .aresetn, .ext_bus_addr_pins, .general_io_pin_81,
   .strap_pins_as_bus, .strap_valid, .boot_source_sel, .ext_bus_cfg,
   .osc_mode_sel, .bus_16bit, .boot_addr, .pll_bypass, .pll_enable,
   .local_power_slot, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
   .s_axi_rready);
